// ---- logic/smac_params.svh ----
// Purpose: shared constants of the secure memory access control block
// Assumes: included by the attempt counter, tear sequencer and access controller files of the block
// Notes: counts are defaults of module parameters
`ifndef SMAC_PARAMS_SVH
`define SMAC_PARAMS_SVH
`define SMAC_ZONES 8
`define SMAC_PW_SETS 8
`define SMAC_KEY_SETS 4
`define SMAC_SET_W 3
`define SMAC_LEN_W 5
`define SMAC_TEAR_PAGE_BYTES 5'h08
`define SMAC_TRIES_MAX 4'h8
`define SMAC_TRIES_W 4
`define SMAC_NVM_DIRECT 2'h0
`define SMAC_NVM_BUFFER 2'h1
`define SMAC_NVM_COPY 2'h2
`endif

// ---- logic/smac_pkg.sv ----
// Purpose: types of the secure memory access control block
// Assumes: nothing
// Notes: code 7 of the command type is unused
package smac_pkg;
    typedef enum logic [2:0] {
        SMAC_OP_READ, SMAC_OP_WRITE, SMAC_OP_CHECK_PW, SMAC_OP_AUTH,
        SMAC_OP_ENC, SMAC_OP_RELEASE, SMAC_OP_IDLE
    } smac_op_type;
    typedef enum logic [2:0] {
        SMAC_ST_OK, SMAC_ST_DENIED, SMAC_ST_TOO_LONG, SMAC_ST_MAC_BAD,
        SMAC_ST_LOCKED, SMAC_ST_FAILED, SMAC_ST_BAD_OP
    } smac_status_type;
    typedef enum {
        SMAC_TEAR_BOOT, SMAC_TEAR_RECOVER, SMAC_TEAR_IDLE, SMAC_TEAR_DIRECT,
        SMAC_TEAR_BUFFER, SMAC_TEAR_COPY
    } smac_tear_state_type;
    typedef struct packed {
        logic valid;
        logic secure;
        logic write;
        logic [2:0] set;
    } smac_pw_type;
endpackage : smac_pkg

// ---- logic/smac_if.sv ----
// Purpose: carriers between the access controller and its helpers
// Assumes: one clock domain
// Notes: idx selects one attempt counter, fail and pass are pulses
interface smac_ctr_if #(parameter int N = 20);
    logic fail;
    logic pass;
    logic [$clog2(N)-1:0] idx;
    logic [N-1:0] locked;
    modport host (output fail, pass, idx, input locked);
    modport ctr (input fail, pass, idx, output locked);
endinterface : smac_ctr_if

interface smac_wr_if;
    logic start;
    logic tear_en;
    logic busy;
    logic done;
    modport host (output start, tear_en, input busy, done);
    modport seq (input start, tear_en, output busy, done);
endinterface : smac_wr_if

// ---- logic/smac_attempt_ctr.sv ----
// Purpose: one attempt counter per password other than the secure code, and per key set
// Assumes: persistence in eeprom is handled by the memory controller
// Notes: a counter saturates at the limit and then locks its entry
`include "smac_params.svh"
module smac_attempt_ctr
    import smac_pkg::*;
#(
    parameter int N = 20,
    parameter logic [`SMAC_TRIES_W-1:0] MAX = `SMAC_TRIES_MAX
) (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // async reset, active low
    smac_ctr_if.ctr ctr // fail or pass events, lock flags
);
    localparam int IW = $clog2(N);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ctr
            logic [`SMAC_TRIES_W-1:0] tries;
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    tries <= '0;
                end else if (ctr.idx == IW'(i)) begin
                    if (ctr.pass) begin
                        tries <= '0;
                    end else if (ctr.fail && tries != MAX) begin
                        tries <= tries + 1'b1;
                    end
                end
            end
            assign ctr.locked[i] = (tries == MAX);
        end
    endgenerate
endmodule : smac_attempt_ctr

// ---- logic/smac_tear_seq.sv ----
// Purpose: eeprom write sequencer with optional anti-tearing
// Assumes: nvm_ack pulses once when a started eeprom cycle ends
// Notes: tear_pending is sampled in the first cycle after reset release
`include "smac_params.svh"
module smac_tear_seq
    import smac_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic resetn, // async reset, active low
    smac_wr_if.seq wr, // write start and completion
    input wire logic tear_pending, // copy was cut by a power loss
    input wire logic nvm_ack, // eeprom cycle finished
    output logic nvm_go, // start one eeprom cycle
    output logic [1:0] nvm_sel // direct, into buffer, or buffer to target
);
    smac_tear_state_type state;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= SMAC_TEAR_BOOT;
            nvm_go <= 1'b0;
            nvm_sel <= `SMAC_NVM_DIRECT;
            wr.busy <= 1'b1;
            wr.done <= 1'b0;
        end else begin
            nvm_go <= 1'b0;
            wr.done <= 1'b0;
            unique case (state)
                SMAC_TEAR_BOOT: begin
                    // restore the target from the buffer before any command
                    state <= tear_pending ? SMAC_TEAR_RECOVER : SMAC_TEAR_IDLE;
                    nvm_go <= tear_pending;
                    nvm_sel <= `SMAC_NVM_COPY;
                    wr.busy <= tear_pending;
                end
                SMAC_TEAR_IDLE: begin
                    if (wr.start) begin
                        state <= wr.tear_en ? SMAC_TEAR_BUFFER : SMAC_TEAR_DIRECT;
                        nvm_sel <= wr.tear_en ? `SMAC_NVM_BUFFER : `SMAC_NVM_DIRECT;
                        nvm_go <= 1'b1;
                        wr.busy <= 1'b1;
                    end
                end
                SMAC_TEAR_BUFFER: begin
                    if (nvm_ack) begin
                        // second eeprom cycle makes protected writes slower
                        state <= SMAC_TEAR_COPY;
                        nvm_sel <= `SMAC_NVM_COPY;
                        nvm_go <= 1'b1;
                    end
                end
                SMAC_TEAR_DIRECT, SMAC_TEAR_COPY, SMAC_TEAR_RECOVER: begin
                    if (nvm_ack) begin
                        state <= SMAC_TEAR_IDLE;
                        wr.busy <= 1'b0;
                        wr.done <= (state != SMAC_TEAR_RECOVER);
                    end
                end
            endcase
        end
    end

    buffer_then_copy_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == SMAC_TEAR_BUFFER && nvm_ack |=> nvm_go && nvm_sel == `SMAC_NVM_COPY)
        else $error("buffered write did not copy to target");
    direct_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == SMAC_TEAR_IDLE && wr.start && !wr.tear_en
        |=> nvm_go && nvm_sel == `SMAC_NVM_DIRECT)
        else $error("unprotected write not sent to target");
    // sampled resetn keeps the releasing edge, still in reset, out of the antecedent
    boot_recover_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == SMAC_TEAR_BOOT && tear_pending && resetn
        |=> nvm_go && nvm_sel == `SMAC_NVM_COPY && wr.busy)
        else $error("torn copy not recovered at power-up");
    buffered_cover_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        state == SMAC_TEAR_COPY && nvm_ack);
endmodule : smac_tear_seq

// ---- logic/smac_access_ctrl.sv ----
// Purpose: session security state and access decisions of a contactless card
// Assumes: decoded commands with compare results; reset is the power-on reset
// Notes: a command is taken on cmd_valid and cmd_ready; one response per command
`include "smac_params.svh"
module smac_access_ctrl
    import smac_pkg::*;
#(
    parameter int ZONES = `SMAC_ZONES,
    parameter int PW_SETS = `SMAC_PW_SETS,
    parameter int KEY_SETS = `SMAC_KEY_SETS
) (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // async power-on reset, active low
    input wire logic cmd_valid, // command present
    input wire logic [2:0] cmd_op, // command code
    input wire logic cmd_cfg, // target is the configuration zone
    input wire logic [2:0] cmd_zone, // user zone
    input wire logic [`SMAC_LEN_W-1:0] cmd_len, // write length in bytes
    input wire logic [2:0] cmd_pw_set, // password set presented
    input wire logic cmd_pw_write, // presented password is the write one
    input wire logic cmd_pw_secure, // presented password is the secure code
    input wire logic cmd_pw_ok, // presented password compared equal
    input wire logic [1:0] cmd_key, // key set for authentication
    input wire logic cmd_key_ok, // authentication or activation verified
    input wire logic cmd_mac_present, // checksum sent with command
    input wire logic cmd_mac_ok, // checksum compared equal
    input wire logic cfg_sec_en, // security features enabled
    input wire logic cfg_tear_en, // anti-tearing enabled
    input wire logic [3*ZONES-1:0] zone_pw_set, // password set of each zone
    input wire logic [ZONES-1:0] zone_need_rpw, // zone read needs password
    input wire logic [ZONES-1:0] zone_need_wpw, // zone write needs password
    input wire logic [ZONES-1:0] zone_need_auth, // zone needs authentication
    input wire logic [ZONES-1:0] zone_need_enc, // zone needs encryption
    input wire logic tear_pending, // anti-tearing flag at power-up
    input wire logic nvm_ack, // eeprom cycle finished
    output logic cmd_ready, // command may be taken
    output logic rsp_valid, // response pulse
    output logic [2:0] rsp_status, // response code
    output logic auth_active, // authentication mode in force
    output logic enc_active, // encryption mode in force
    output logic pw_active, // a password is in force
    output logic mac_mode, // checksum is a mac, not an mdc
    output logic pw_encrypted, // password data travels ciphered
    output logic tx_encrypt, // cipher outgoing read data
    output logic rx_decrypt, // decipher incoming write and password data
    output logic nvm_go, // start one eeprom cycle
    output logic [1:0] nvm_sel // eeprom cycle kind
);
    localparam int N_CTR = 2 * PW_SETS + KEY_SETS;
    localparam int CW = $clog2(N_CTR);

    smac_ctr_if #(.N(N_CTR)) ctr_bus ();
    smac_wr_if wr_bus ();

    smac_op_type op;
    smac_pw_type pw;
    logic take;
    logic crypt;
    logic [2:0] zset;
    logic match_rd;
    logic match_wr;
    logic rd_ok;
    logic wr_ok;
    logic mac_bad;
    logic launch;
    logic wr_wait;
    smac_status_type next_status;

    assign op = smac_op_type'(cmd_op);
    assign take = cmd_valid && cmd_ready;
    assign crypt = auth_active || enc_active;
    assign zset = zone_pw_set[3*cmd_zone +: 3];
    assign match_rd = pw.valid && !pw.secure && pw.set == zset;
    assign match_wr = match_rd && pw.write;

    smac_attempt_ctr #(.N(N_CTR)) u_ctr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ctr(ctr_bus)
    );

    smac_tear_seq u_tear (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wr(wr_bus),
        .tear_pending(tear_pending),
        .nvm_ack(nvm_ack),
        .nvm_go(nvm_go),
        .nvm_sel(nvm_sel)
    );

    // with security off every user zone is open to plain commands
    always_comb begin
        rd_ok = !cfg_sec_en;
        wr_ok = !cfg_sec_en;
        if (cfg_sec_en) begin
            rd_ok = (!zone_need_rpw[cmd_zone] || match_rd)
                && (!zone_need_auth[cmd_zone] || auth_active)
                && (!zone_need_enc[cmd_zone] || enc_active);
            wr_ok = (!zone_need_wpw[cmd_zone] || match_wr)
                && (!zone_need_auth[cmd_zone] || auth_active)
                && (!zone_need_enc[cmd_zone] || enc_active);
        end
        if (cmd_cfg) begin
            rd_ok = pw.valid && pw.secure;
            wr_ok = pw.valid && pw.secure;
        end
    end

    // standard mode: checksum optional; crypto mode: writes must carry a mac
    always_comb begin
        mac_bad = cmd_mac_present && !cmd_mac_ok;
        if (crypt && op == SMAC_OP_WRITE && !cmd_mac_present) begin
            mac_bad = 1'b1;
        end
    end

    always_comb begin
        ctr_bus.idx = CW'({cmd_pw_set, cmd_pw_write});
        if (op == SMAC_OP_AUTH || op == SMAC_OP_ENC) begin
            ctr_bus.idx = CW'(2 * PW_SETS) + CW'(cmd_key);
        end
        ctr_bus.fail = 1'b0;
        ctr_bus.pass = 1'b0;
        launch = 1'b0;
        next_status = SMAC_ST_OK;
        unique case (op)
            SMAC_OP_READ: begin
                if (mac_bad) begin
                    next_status = SMAC_ST_MAC_BAD;
                end else if (!rd_ok) begin
                    next_status = SMAC_ST_DENIED;
                end
            end
            SMAC_OP_WRITE: begin
                if (mac_bad) begin
                    next_status = SMAC_ST_MAC_BAD;
                end else if (!wr_ok) begin
                    next_status = SMAC_ST_DENIED;
                end else if (cfg_tear_en && cmd_len > `SMAC_TEAR_PAGE_BYTES) begin
                    next_status = SMAC_ST_TOO_LONG;
                end else begin
                    launch = take;
                end
            end
            SMAC_OP_CHECK_PW, SMAC_OP_AUTH, SMAC_OP_ENC: begin
                if (mac_bad) begin
                    next_status = SMAC_ST_MAC_BAD;
                end else if (!cmd_pw_secure && ctr_bus.locked[ctr_bus.idx]) begin
                    next_status = SMAC_ST_LOCKED;
                end else if (!cmd_pw_ok && op == SMAC_OP_CHECK_PW) begin
                    next_status = SMAC_ST_FAILED;
                end else if (op != SMAC_OP_CHECK_PW && !cmd_key_ok) begin
                    next_status = SMAC_ST_FAILED;
                end else if (op == SMAC_OP_ENC && !auth_active) begin
                    next_status = SMAC_ST_FAILED;
                end
                if (!cmd_pw_secure || op != SMAC_OP_CHECK_PW) begin
                    ctr_bus.fail = take && next_status == SMAC_ST_FAILED;
                    ctr_bus.pass = take && next_status == SMAC_ST_OK;
                end
            end
            SMAC_OP_RELEASE, SMAC_OP_IDLE: begin
                next_status = mac_bad ? SMAC_ST_MAC_BAD : SMAC_ST_OK;
            end
            default: begin
                next_status = mac_bad ? SMAC_ST_MAC_BAD : SMAC_ST_BAD_OP;
            end
        endcase
    end

    assign wr_bus.start = launch;
    assign wr_bus.tear_en = cfg_tear_en;

    // the active password; a new presentation replaces the old one unless its checksum is bad
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pw <= '0;
        end else if (take && (op == SMAC_OP_RELEASE || op == SMAC_OP_IDLE)) begin
            pw <= '0;
        end else if (take && op == SMAC_OP_CHECK_PW && next_status != SMAC_ST_MAC_BAD) begin
            pw.valid <= (next_status == SMAC_ST_OK);
            pw.secure <= cmd_pw_secure;
            pw.write <= cmd_pw_write;
            pw.set <= cmd_pw_set;
        end
    end

    // authentication and encryption session state
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            auth_active <= 1'b0;
            enc_active <= 1'b0;
        end else if (take) begin
            if (op == SMAC_OP_RELEASE || op == SMAC_OP_IDLE) begin
                auth_active <= 1'b0;
                enc_active <= 1'b0;
            end else if (crypt && next_status == SMAC_ST_MAC_BAD) begin
                // only a fresh authentication brings crypto mode back
                auth_active <= 1'b0;
                enc_active <= 1'b0;
            end else if (op == SMAC_OP_AUTH) begin
                auth_active <= (next_status == SMAC_ST_OK);
                enc_active <= 1'b0;
            end else if (op == SMAC_OP_ENC) begin
                enc_active <= (next_status == SMAC_ST_OK);
            end
        end
    end

    // cipher and checksum mode outputs follow the session state
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pw_active <= 1'b0;
            mac_mode <= 1'b0;
            pw_encrypted <= 1'b0;
            tx_encrypt <= 1'b0;
            rx_decrypt <= 1'b0;
        end else begin
            pw_active <= pw.valid;
            mac_mode <= crypt;
            pw_encrypted <= crypt;
            tx_encrypt <= enc_active;
            rx_decrypt <= enc_active;
        end
    end

    // responses: at once for most commands, at completion for granted writes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid <= 1'b0;
            rsp_status <= 3'h0;
            wr_wait <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            rsp_valid <= (take && !launch) || wr_bus.done;
            if (take && !launch) begin
                rsp_status <= next_status;
            end else if (wr_bus.done) begin
                rsp_status <= SMAC_ST_OK;
            end
            if (launch) begin
                wr_wait <= 1'b1;
            end else if (wr_bus.done) begin
                wr_wait <= 1'b0;
            end
            cmd_ready <= !wr_bus.busy && !wr_wait && !launch;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    release_clears_a: assert property (
        take && (op == SMAC_OP_RELEASE || op == SMAC_OP_IDLE)
        |=> !auth_active && !enc_active && !pw.valid ##1 !pw_active && !tx_encrypt)
        else $error("release left session state active");
    pw_held_a: assert property (
        pw.valid && !take |=> $stable(pw))
        else $error("active password changed without a command");
    auth_fail_a: assert property (
        take && op == SMAC_OP_AUTH && !cmd_key_ok |=> !auth_active && rsp_valid)
        else $error("failed authentication kept old state");
    enc_needs_auth_a: assert property (
        take && op == SMAC_OP_ENC && !auth_active |=> !enc_active)
        else $error("encryption entered without authentication");
    mac_reset_a: assert property (
        take && crypt && cmd_mac_present && !cmd_mac_ok
        |=> !auth_active && !enc_active && rsp_status == SMAC_ST_MAC_BAD && !nvm_go)
        else $error("mac mismatch did not drop crypto mode");
    enc_zone_a: assert property (
        take && (op == SMAC_OP_READ || op == SMAC_OP_WRITE) && !cmd_cfg && cfg_sec_en
        && zone_need_enc[cmd_zone] && !enc_active |=> rsp_valid && rsp_status != SMAC_ST_OK)
        else $error("encryption zone reached without encryption");
    tear_page_a: assert property (
        take && op == SMAC_OP_WRITE && cfg_tear_en && cmd_len > `SMAC_TEAR_PAGE_BYTES
        |=> rsp_valid && !nvm_go)
        else $error("oversized protected write accepted");
    refused_quiet_a: assert property (
        take && !launch && wr_bus.busy == 1'b0 |=> !nvm_go)
        else $error("refused command started an eeprom cycle");
    cipher_off_a: assert property (
        take && op == SMAC_OP_ENC && !cmd_key_ok |=> ##1 !tx_encrypt && !rx_decrypt)
        else $error("cipher still on after failed activation");
    cfg_gate_a: assert property (
        take && cmd_cfg && op == SMAC_OP_WRITE && !(pw.valid && pw.secure) |=> !nvm_go)
        else $error("config written without secure code");

    auth_enc_cover_c: cover property (
        take && op == SMAC_OP_ENC && auth_active && cmd_key_ok ##1 enc_active);
    write_done_cover_c: cover property (launch ##[1:40] wr_bus.done);
    lock_cover_c: cover property (take && next_status == SMAC_ST_LOCKED);
endmodule : smac_access_ctrl

// ---- tb/smac_nvm_model.sv ----
// Purpose: eeprom stand-in that acknowledges every started cycle
// Assumes: one nvm_ack is owed for each nvm_go
// Notes: DLY sets the length of one eeprom cycle in clocks
module smac_nvm_model #(parameter int DLY = 3) (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic nvm_go, // start one eeprom cycle
    output logic nvm_ack // cycle finished pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            nvm_ack <= 1'b0;
        end else begin
            nvm_ack <= (cnt == 1);
            if (nvm_go) cnt <= DLY;
            else if (cnt > 0) cnt <= cnt - 1;
        end
    end
endmodule : smac_nvm_model

// ---- tb/test_secure_memory_access_control.sv ----
// Purpose: self-checking bench of the access controller
// Assumes: eeprom model answers every started cycle
// Notes: command fields are set before each issue call
module test_secure_memory_access_control
    import smac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, resetn = 0, cmd_valid = 0, cmd_cfg = 0, cmd_pw_write = 0;
    logic cmd_pw_secure = 0, cmd_pw_ok = 0, cmd_key_ok = 0, cmd_mac_present = 1, cmd_mac_ok = 1;
    logic cfg_sec_en = 0, cfg_tear_en = 0, tear_pending = 1, nvm_ack, nvm_go, cmd_ready, rsp_valid;
    logic [2:0] cmd_op = 0, cmd_zone = 0, cmd_pw_set = 0, rsp_status;
    logic [4:0] cmd_len = 5'h01;
    logic [23:0] zone_pw_set = 24'h000008;
    logic [7:0] need_rpw = 8'h00, need_enc = 8'h00, gos [3] = '{8'h00, 8'h00, 8'h00};
    logic auth_active, enc_active, pw_active, mac_mode, pw_encrypted, tx_encrypt, rx_decrypt;
    logic [1:0] nvm_sel;
    int failures = 0, n_compared = 0;
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (nvm_go === 1'b1) gos[nvm_sel] <= gos[nvm_sel] + 8'h01;
    smac_access_ctrl smac_access_ctrl_i (.sys_clk(sys_clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_cfg(cmd_cfg), .cmd_zone(cmd_zone),
        .cmd_len(cmd_len), .cmd_pw_set(cmd_pw_set), .cmd_pw_write(cmd_pw_write),
        .cmd_pw_secure(cmd_pw_secure), .cmd_pw_ok(cmd_pw_ok), .cmd_key(2'h1),
        .cmd_key_ok(cmd_key_ok), .cmd_mac_present(cmd_mac_present), .cmd_mac_ok(cmd_mac_ok),
        .cfg_sec_en(cfg_sec_en), .cfg_tear_en(cfg_tear_en), .zone_pw_set(zone_pw_set),
        .zone_need_rpw(need_rpw), .zone_need_wpw(need_rpw), .zone_need_auth(8'h00),
        .zone_need_enc(need_enc), .tear_pending(tear_pending), .nvm_ack(nvm_ack),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
        .auth_active(auth_active), .enc_active(enc_active), .pw_active(pw_active),
        .mac_mode(mac_mode), .pw_encrypted(pw_encrypted), .tx_encrypt(tx_encrypt),
        .rx_decrypt(rx_decrypt), .nvm_go(nvm_go), .nvm_sel(nvm_sel));
    smac_nvm_model smac_nvm_model_i (.sys_clk(sys_clk), .resetn(resetn), .nvm_go(nvm_go),
        .nvm_ack(nvm_ack));
    task conclude;
        $display("compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task bound(input int n);
        if (n >= 300) begin
            failures++;
            $display("ERROR wait limit used up");
            conclude();
        end
    endtask : bound
    // waits for ready, takes one command, checks the status, lets modes settle
    task issue(input logic [2:0] op, input logic [2:0] exp);
        int n;
        for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
        bound(n);
        @(posedge sys_clk);
        cmd_op <= op;
        cmd_valid <= 1'b1;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 300 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
        bound(n);
        chk("rsp_status", {5'h00, exp}, {5'h00, rsp_status});
        @(negedge sys_clk);
        @(posedge sys_clk);
    endtask : issue
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        issue(SMAC_OP_READ, SMAC_ST_OK);
        chk("recovery copies", 8'h01, gos[2]);
        $display("test done: power-up recovery and open reads");
        cmd_cfg <= 1'b1;
        issue(SMAC_OP_READ, SMAC_ST_DENIED);
        {cmd_pw_secure, cmd_pw_ok} <= 2'h3;
        issue(SMAC_OP_CHECK_PW, SMAC_ST_OK);
        issue(SMAC_OP_READ, SMAC_ST_OK);
        {cmd_cfg, cmd_pw_secure, cmd_len} <= {2'h0, 5'h10};
        issue(SMAC_OP_WRITE, SMAC_ST_OK);
        chk("direct cycles", 8'h01, gos[0]);
        {cfg_tear_en, cmd_len} <= {1'b1, 5'h09};
        issue(SMAC_OP_WRITE, SMAC_ST_TOO_LONG);
        cmd_len <= 5'h08;
        issue(SMAC_OP_WRITE, SMAC_ST_OK);
        chk("buffer then copy", 8'h12, {gos[1][3:0], gos[2][3:0]});
        $display("test done: config access and write paths");
        {cfg_sec_en, need_rpw, cmd_zone, cmd_pw_set} <= {1'b1, 8'h02, 3'h1, 3'h1};
        issue(SMAC_OP_READ, SMAC_ST_DENIED);
        cmd_pw_write <= 1'b1;
        issue(SMAC_OP_CHECK_PW, SMAC_ST_OK);
        chk("pw_active", 8'h01, {7'h00, pw_active});
        issue(SMAC_OP_READ, SMAC_ST_OK);
        issue(SMAC_OP_RELEASE, SMAC_ST_OK);
        issue(SMAC_OP_READ, SMAC_ST_DENIED);
        $display("test done: passwords");
        {cmd_key_ok, need_enc, cmd_zone} <= {1'b1, 8'h04, 3'h2};
        issue(SMAC_OP_AUTH, SMAC_ST_OK);
        chk("auth modes", 8'h07, {5'h00, auth_active, mac_mode, pw_encrypted});
        issue(SMAC_OP_READ, SMAC_ST_DENIED);
        issue(SMAC_OP_ENC, SMAC_ST_OK);
        chk("enc modes", 8'h07, {5'h00, enc_active, tx_encrypt, rx_decrypt});
        issue(SMAC_OP_READ, SMAC_ST_OK);
        cmd_key_ok <= 1'b0;
        issue(SMAC_OP_ENC, SMAC_ST_FAILED);
        chk("enc dropped", 8'h00, {6'h00, tx_encrypt, rx_decrypt});
        issue(SMAC_OP_AUTH, SMAC_ST_FAILED);
        chk("auth dropped", 8'h00, {7'h00, auth_active});
        cmd_key_ok <= 1'b1;
        issue(SMAC_OP_AUTH, SMAC_ST_OK);
        {cmd_mac_ok, cmd_zone} <= {1'b0, 3'h0};
        issue(SMAC_OP_WRITE, SMAC_ST_MAC_BAD);
        chk("crypto left", 8'h00, {6'h00, auth_active, mac_mode});
        chk("no eeprom touch", 8'h12, {gos[1][3:0], gos[2][3:0]});
        cmd_mac_present <= 1'b0;
        issue(3'h7, SMAC_ST_BAD_OP);
        issue(SMAC_OP_WRITE, SMAC_ST_OK);
        $display("test done: authentication and encryption");
        issue(SMAC_OP_AUTH, SMAC_ST_OK);
        issue(SMAC_OP_CHECK_PW, SMAC_ST_OK);
        chk("session before loss", 8'h03, {6'h00, pw_active, auth_active});
        {resetn, tear_pending} <= 2'h0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        issue(SMAC_OP_READ, SMAC_ST_OK);
        chk("power loss clears", 8'h00, {6'h00, pw_active, auth_active});
        chk("no copy unflagged", 8'h03, gos[2]);
        $display("test done: power loss");
        conclude();
    end
endmodule : test_secure_memory_access_control
